// ===== rit_chk.sv
/* port checker for the interval timer: apb answers and interrupt level.
   assumes a bind onto rit_timer and a single pclk domain. */
`timescale 1ns/10ps
module rit_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        timer_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_in_access: assert property (pslverr |-> acc) else $error("pslverr outside access");
  a_unmapped_refused: assert property (acc && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_ctrl_unimpl_zero: assert property (
    acc && !pwrite && paddr == 12'h000 |-> (prdata & 32'hffff5f89) == 32'h0)
    else $error("unimplemented control bit reads one");
  a_upper_half_zero: assert property (
    acc && !pwrite && paddr <= 12'h008 |-> prdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_irq_low_reset: assert property ($rose(presetn) |-> !timer_irq)
    else $error("interrupt high out of reset");
  a_irq_fall_write: assert property ($fell(timer_irq) |-> $past(acc && pwrite))
    else $error("interrupt fell without a write");
endmodule // rit_chk
bind rit_timer rit_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_irq(timer_irq));

// ===== rit_consts.vh
/*
  constants for the interval timer: register offsets, control bit positions,
  reset values and prescale ratios. assumes inclusion by the timer module only.
*/
`ifndef RIT_CONSTS_VH
`define RIT_CONSTS_VH

`define RIT_OFF_CTRL      12'h000
`define RIT_OFF_COUNT     12'h004
`define RIT_OFF_PERIOD    12'h008
`define RIT_OFF_STATUS    12'h00c
`define RIT_OFF_MASK      12'h010

`define RIT_B_RUN         15
`define RIT_B_IDLE        13
`define RIT_B_GATE        6
`define RIT_B_PS_HI       5
`define RIT_B_PS_LO       4
`define RIT_B_SYNC        2
`define RIT_B_SRC         1
`define RIT_CTRL_WMASK    16'ha076

`define RIT_CTRL_RST      16'h0000
`define RIT_COUNT_RST     16'h0000
`define RIT_PERIOD_RST    16'hffff
`define RIT_ZERO16        16'h0000
`define RIT_ONE16         16'h0001
`define RIT_ZERO8         8'h00
`define RIT_ONE8          8'h01

`define RIT_DIV_1         8'h00
`define RIT_DIV_8         8'h07
`define RIT_DIV_64        8'h3f
`define RIT_DIV_256       8'hff

`define RIT_EV_MATCH      0
`define RIT_EV_GATE       1
`define RIT_EV_W          2

`endif

// ===== rit_pin_src.sv
/* external count source model: bursts of clean pulses on the count pin.
   assumes the bench calls burst; the pin rests low between bursts. */
`timescale 1ns/10ps
module rit_pin_src (
  output logic ext_count_pin
);
  initial ext_count_pin = 1'b0;
  task automatic burst(input int n, input int half_ns);
    repeat (n) begin
      #(half_ns) ext_count_pin = 1'b1;
      #(half_ns) ext_count_pin = 1'b0;
    end
  endtask
endmodule // rit_pin_src

// ===== rit_timer.v
/*
  16-bit interval timer with apb register access, prescaler, gating,
  synchronous and asynchronous external counting, period match and interrupt.
  assumes pclk is the instruction-cycle clock and ext_count_pin arrives
  as a clean clock from the outside (crystal or other source).
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "rit_consts.vh"

module rit_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ext_count_pin,
  input  wire        gate_in,
  input  wire        chip_idle,
  output wire        timer_irq
);

  reg  [15:0] timer_control_r;
  reg  [15:0] count_r;
  reg  [15:0] period_r;
  reg  [`RIT_EV_W-1:0] status_r;
  reg  [`RIT_EV_W-1:0] mask_r;
  reg  [7:0]  pre_r;
  reg         gate_d_r;
  reg         ext_pre_tog_r;
  reg  [2:0]  ext_sync_r;
  reg  [15:0] acount_r;
  reg  [7:0]  apre_r;
  reg         amatch_tog_r;
  reg  [2:0]  amatch_sync_r;
  reg  [15:0] acount_snap_r;
  reg         async_arm_r;
  reg  [7:0]  xpre_r;

  wire        run      = timer_control_r[`RIT_B_RUN];
  wire        idle_halt = timer_control_r[`RIT_B_IDLE];
  wire        gate_accumulate = timer_control_r[`RIT_B_GATE];
  wire [1:0]  prescale_select = timer_control_r[`RIT_B_PS_HI:`RIT_B_PS_LO];
  wire        ext_clock_sync = timer_control_r[`RIT_B_SYNC];
  wire        clock_source_sel = timer_control_r[`RIT_B_SRC];

  function [7:0] rit_div;
    input [1:0] sel;
    begin
      case (sel)
        2'b11:   rit_div = `RIT_DIV_256;
        2'b10:   rit_div = `RIT_DIV_64;
        2'b01:   rit_div = `RIT_DIV_8;
        default: rit_div = `RIT_DIV_1;
      endcase
    end
  endfunction

  wire [7:0]  div_max  = rit_div(prescale_select);
  wire        active   = run & ~(idle_halt & chip_idle);
  // source bit picks pin or internal clock
  wire        mode_int   = ~clock_source_sel;
  // gate only meaningful with internal clock
  wire        mode_gated = mode_int & gate_accumulate;
  // sync bit only meaningful with external clock
  wire        mode_sync  = clock_source_sel & ext_clock_sync;
  wire        mode_async = clock_source_sel & ~ext_clock_sync;

  wire        apb_wr = psel & penable & pwrite;
  wire        sel_ctrl   = (paddr == `RIT_OFF_CTRL);
  wire        sel_count  = (paddr == `RIT_OFF_COUNT);
  wire        sel_period = (paddr == `RIT_OFF_PERIOD);
  wire        sel_status = (paddr == `RIT_OFF_STATUS);
  wire        sel_mask   = (paddr == `RIT_OFF_MASK);
  wire        mapped = sel_ctrl | sel_count | sel_period | sel_status | sel_mask;

  // internal ticks: instruction-cycle clock through prescaler
  // gated mode only ticks while gate input is high
  wire        int_en   = active & mode_int & (~gate_accumulate | gate_in);
  wire        int_tick = int_en & (pre_r == div_max);

  // external edges are prescaled in the pin domain, the
  // prescaled toggle is then synchronized; a toggle survives slow pclk gaps
  always @(posedge ext_count_pin or negedge presetn) begin
    if (!presetn) begin
      xpre_r        <= `RIT_ZERO8;
      ext_pre_tog_r <= 1'b0;
    end else if (active & mode_sync) begin
      // one rising edge, one input count
      if (xpre_r == div_max) begin
        xpre_r        <= `RIT_ZERO8;
        ext_pre_tog_r <= ~ext_pre_tog_r;
      end else begin
        xpre_r <= xpre_r + `RIT_ONE8;
      end
    end
  end

  // first stage only feeds the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_sync_r <= 3'b000;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_pre_tog_r};
    end
  end

  wire        sync_tick = active & mode_sync & (ext_sync_r[2] ^ ext_sync_r[1]);
  wire        tick     = int_tick | sync_tick;
  wire        match    = tick & (count_r == period_r);
  wire        gate_fall = mode_gated & active & gate_d_r & ~gate_in;

  // asynchronous counter runs entirely on the pin clock
  // a 32 kHz crystal on the pin keeps time with no pclk edges
  always @(posedge ext_count_pin or negedge presetn) begin
    if (!presetn) begin
      acount_r     <= `RIT_COUNT_RST;
      apre_r       <= `RIT_ZERO8;
      amatch_tog_r <= 1'b0;
    end else if (active & mode_async) begin
      if (apre_r == div_max) begin
        apre_r <= `RIT_ZERO8;
        if (acount_r == period_r) begin
          acount_r     <= `RIT_ZERO16;
          amatch_tog_r <= ~amatch_tog_r;
        end else begin
          acount_r <= acount_r + `RIT_ONE16;
        end
      end else begin
        apre_r <= apre_r + `RIT_ONE8;
      end
    end
  end

  // match toggle crosses by two flops; count snapshot only trusted when
  // the pin clock is slow next to pclk (crystal use), a known limitation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amatch_sync_r <= 3'b000;
      acount_snap_r <= `RIT_COUNT_RST;
      async_arm_r   <= 1'b0;
    end else begin
      amatch_sync_r <= {amatch_sync_r[1:0], amatch_tog_r};
      acount_snap_r <= acount_r;
      async_arm_r   <= mode_async;
    end
  end

  wire        amatch = async_arm_r & (amatch_sync_r[2] ^ amatch_sync_r[1]);
  wire [15:0] count_view = mode_async ? acount_snap_r : count_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_r <= `RIT_CTRL_RST;
      count_r         <= `RIT_COUNT_RST;
      period_r        <= `RIT_PERIOD_RST;
      pre_r           <= `RIT_ZERO8;
      gate_d_r        <= 1'b0;
      status_r        <= {`RIT_EV_W{1'b0}};
      mask_r          <= {`RIT_EV_W{1'b0}};
    end else begin
      gate_d_r <= gate_in;
      if (int_en) begin
        pre_r <= (pre_r == div_max) ? `RIT_ZERO8 : pre_r + `RIT_ONE8;
      end
      if (apb_wr & sel_count) begin
        count_r <= pwdata[15:0];
      end else if (match) begin
        count_r <= `RIT_ZERO16;
      end else if (tick) begin
        count_r <= count_r + `RIT_ONE16;
      end
      if (apb_wr & sel_ctrl) begin
        timer_control_r <= pwdata[15:0] & `RIT_CTRL_WMASK;
      end
      if (apb_wr & sel_period) begin
        period_r <= pwdata[15:0];
      end
      if (apb_wr & sel_mask) begin
        mask_r <= pwdata[`RIT_EV_W-1:0];
      end
      // set wins over write-one-to-clear
      status_r[`RIT_EV_MATCH] <= (match | amatch) |
        (status_r[`RIT_EV_MATCH] & ~(apb_wr & sel_status & pwdata[`RIT_EV_MATCH]));
      status_r[`RIT_EV_GATE] <= gate_fall |
        (status_r[`RIT_EV_GATE] & ~(apb_wr & sel_status & pwdata[`RIT_EV_GATE]));
    end
  end

  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    case (1'b1)
      sel_ctrl:   rdata[15:0] = timer_control_r;
      sel_count:  rdata[15:0] = count_view;
      sel_period: rdata[15:0] = period_r;
      sel_status: rdata[`RIT_EV_W-1:0] = status_r;
      sel_mask:   rdata[`RIT_EV_W-1:0] = mask_r;
      default:    rdata = 32'h0000_0000;
    endcase
  end

  assign prdata    = rdata;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;
  assign timer_irq = |(status_r & mask_r);

endmodule // rit_timer

// ===== tb_top.sv
/* self-checking bench for rit_timer: apb tasks, mode runs, interrupts.
   assumes zero-wait apb and the pin source model beside the timer. */
`timescale 1ns/10ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, gate_in, chip_idle;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, ext_count_pin, timer_irq, err;
  int          fail_count, tests_run;
  rit_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(ext_count_pin), .gate_in(gate_in),
    .chip_idle(chip_idle), .timer_irq(timer_irq));
  rit_pin_src src (.ext_count_pin(ext_count_pin));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      fail_count++;
      tally_and_finish;
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // prescaler phase leaves one count of slack
  task near(input logic [15:0] got, input logic [15:0] exp);
    chk((got === exp - 16'h1) ? exp : got, exp);
  endtask
  task run_int(input logic [15:0] c, input logic g, input logic idl, input logic [15:0] e);
    gate_in <= g; chip_idle <= idl;
    apb(12'h004, 1'b1, 32'h0); apb(12'h000, 1'b1, {16'h0, c});
    repeat (509) @(posedge pclk);
    apb(12'h000, 1'b1, 32'h0); apb(12'h004, 1'b0, 32'h0);
    near(rdv[15:0], e);
  endtask
  task run_ext(input logic [15:0] c, input int n, input logic [15:0] e);
    apb(12'h000, 1'b1, {16'h0, c}); apb(12'h004, 1'b1, 32'h0);
    src.burst(n, 20);
    repeat (8) @(posedge pclk);
    apb(12'h004, 1'b0, 32'h0);
    near(rdv[15:0], e);
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; gate_in = 1'b0; chip_idle = 1'b0; fail_count = 0; tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h000, 1'b0, 32'h0); chk(rdv[15:0], 16'h0);
    apb(12'h000, 1'b1, 32'hffffffff); apb(12'h000, 1'b0, 32'h0); chk(rdv[15:0], 16'ha076);
    apb(12'h020, 1'b0, 32'h0); chk(rdv[15:0], 16'h0);
    chk({15'h0, err}, 16'h1);
    apb(12'h008, 1'b0, 32'h0); chk({15'h0, err}, 16'h0);
    chk(rdv[15:0], 16'hffff);
    run_ext(16'h8002, 10, 16'd10);
    run_ext(16'h8046, 20, 16'd20);
    run_ext(16'h8016, 16, 16'd2);
    run_int(16'h8000, 1'b0, 1'b0, 16'd512);
    run_int(16'h8010, 1'b0, 1'b0, 16'd64);
    run_int(16'h8020, 1'b0, 1'b0, 16'd8);
    run_int(16'h8030, 1'b0, 1'b0, 16'd2);
    run_int(16'ha000, 1'b0, 1'b1, 16'd0);
    run_int(16'h8000, 1'b0, 1'b1, 16'd512);
    run_int(16'h8040, 1'b0, 1'b0, 16'd0);
    run_int(16'h8040, 1'b1, 1'b0, 16'd512);
    apb(12'h008, 1'b1, 32'h4); apb(12'h010, 1'b1, 32'h1); apb(12'h004, 1'b1, 32'h0);
    apb(12'h000, 1'b1, 32'h8000);
    repeat (12) @(posedge pclk);
    chk({15'h0, timer_irq}, 16'h1);
    apb(12'h000, 1'b1, 32'h0); apb(12'h00c, 1'b0, 32'h0); chk(rdv[15:0] & 16'h1, 16'h1);
    apb(12'h00c, 1'b1, 32'h3);
    @(posedge pclk);
    chk({15'h0, timer_irq}, 16'h0);
    apb(12'h010, 1'b1, 32'h2); apb(12'h000, 1'b1, 32'h8040);
    repeat (3) @(posedge pclk);
    gate_in <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({15'h0, timer_irq}, 16'h1);
    tally_and_finish;
  end
endmodule // tb_top
